// ---- dv/bus_master_model.sv ----
// processor core model driving the peripheral bus
// assumes a slave that answers in the access phase
`timescale 1ns/1ps
module bus_master_model (
	input wire logic mclk_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [periph_pkg::ADDR_W-1:0] paddr_o,
	output logic [periph_pkg::DATA_W-1:0] pwdata_o,
	input wire logic [periph_pkg::DATA_W-1:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic irqc_sel_i
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 16'h0000;
		pwdata_o = 32'h00000000;
	end
	// always a full word on the bus; callers keep unused bits zero
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err, output logic sel, output logic ok);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge mclk_i);
		penable_o <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 8);
		ok = (pready_i === 1'b1);
		q = prdata_i;
		err = pslverr_i;
		sel = irqc_sel_i;
		// released lines show the inverse so stale values are not mistaken for live ones
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
endmodule // bus_master_model

// ---- dv/test_peripheral_regs_irq_and_pdc.sv ----
// testbench for the register bank with its four data channels
// assumes the bus master model and a reference model kept here
`timescale 1ns/1ps
module test_peripheral_regs_irq_and_pdc;
	logic mclk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irqc_sel_o;
	logic [15:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic [1:0] irq_o, rx_req_i, tx_req_i, rx_ack_o, tx_ack_o;
	logic [1:0][7:0] mode_o;
	logic [1:0][31:0] rx_addr_o, tx_addr_o;
	logic [3:0] req;
	int mismatches, check_count, i, c, p, d, n;
	bit m_en[4];
	int m_cnt[4];
	logic [31:0] m_ptr[4], v, q;
	logic [3:0] m_mask[2];
	logic e, s, k;
	logic [15:0] bad_q[$] = '{16'h0020, 16'h4040, 16'h9000, 16'hC000, 16'h8004};
	assign rx_req_i = {req[2], req[0]};
	assign tx_req_i = {req[3], req[1]};
	periph_regs periph_regs_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .irqc_sel_o(irqc_sel_o), .irq_o(irq_o), .mode_o(mode_o), .rx_req_i(rx_req_i),
		.tx_req_i(tx_req_i), .rx_ack_o(rx_ack_o), .tx_ack_o(tx_ack_o), .rx_addr_o(rx_addr_o), .tx_addr_o(tx_addr_o));
	bus_master_model bus_master_model_inst (.mclk_i(mclk_i), .psel_o(psel_i), .penable_o(penable_i),
		.pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o),
		.pslverr_i(pslverr_o), .irqc_sel_i(irqc_sel_o));
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// --------------------------------------------------
	// checking and bus helpers
	// --------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] dv);
		logic [31:0] r;
		logic er, sl, ok;
		bus_master_model_inst.xfer(1'b1, a, dv, r, er, sl, ok);
		chk("write answer", 32'h1, {31'h0, ok & ~er});
	endtask
	task automatic rd(input string what, input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic er, sl, ok;
		bus_master_model_inst.xfer(1'b0, a, 32'h0, r, er, sl, ok);
		chk({what, " answer"}, 32'h1, {31'h0, ok & ~er});
		chk(what, exp, r);
	endtask
	function automatic logic [15:0] ra(int pp, logic [13:0] off);
		return {pp[1:0], off};
	endfunction
	function automatic logic [31:0] m_stat(int pp);
		return {28'h0, m_en[2*pp+1], m_en[2*pp], m_cnt[2*pp+1] == 0, m_cnt[2*pp] == 0};
	endfunction
	task automatic chk_irq(int pp);
		logic [31:0] st;
		st = m_stat(pp);
		chk("interrupt", {31'h0, |(st[3:0] & m_mask[pp])}, {31'h0, irq_o[pp]});
	endtask
	// requests sampled on k edges back to back; each ack is checked one edge later
	task automatic burst(int ch, int kk);
		logic ea;
		logic [31:0] eaddr, got;
		ea = 1'b0;
		eaddr = 32'h0;
		for (int j = 0; j <= kk + 1; j++) begin
			@(posedge mclk_i);
			got = ch[0] ? tx_addr_o[ch>>1] : rx_addr_o[ch>>1];
			if (j >= 2) chk("transfer ack", {31'h0, ea}, {31'h0, ch[0] ? tx_ack_o[ch>>1] : rx_ack_o[ch>>1]});
			if (j >= 2 && ea) chk("transfer address", eaddr, got);
			if (j >= 1 && j <= kk) begin
				ea = m_en[ch] && m_cnt[ch] > 0;
				if (ea) begin
					eaddr = m_ptr[ch];
					m_ptr[ch] = m_ptr[ch] + periph_pkg::XFER_SIZE;
					m_cnt[ch]--;
				end
			end
			if (j == 0) req[ch] <= 1'b1;
			if (j == kk) req[ch] <= 1'b0;
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk_i);
		mismatches++;
		test_done();
	end
	// --------------------------------------------------
	// tests
	// --------------------------------------------------
	initial begin
		nrst_i = 1'b0;
		req = 4'h0;
		mismatches = 0;
		check_count = 0;
		v = $urandom(32'hC95F);
		for (i = 0; i < 4; i++) begin
			m_en[i] = 0;
			m_cnt[i] = 0;
			m_ptr[i] = 32'h0;
		end
		m_mask = '{4'h0, 4'h0};
		repeat (12) @(posedge mclk_i);
		nrst_i <= 1'b1;
		for (p = 0; p < 2; p++) begin
			rd("mode", ra(p, periph_pkg::OFF_MODE), 32'h0);
			rd("mask", ra(p, periph_pkg::OFF_IMASK), 32'h0);
			rd("status", ra(p, periph_pkg::OFF_STAT), m_stat(p));
			rd("pointer", ra(p, periph_pkg::OFF_TX_PTR), 32'h0);
			rd("count", ra(p, periph_pkg::OFF_RX_CNT), 32'h0);
		end
		$display("test reset_values done");
		for (p = 0; p < 2; p++) begin
			m_ptr[p] = $urandom & 32'h000000FF;
			wr(ra(p, periph_pkg::OFF_MODE) | 16'h0002, m_ptr[p]);
		end
		for (p = 0; p < 2; p++) begin
			rd("mode", ra(p, periph_pkg::OFF_MODE) | 16'h0001, m_ptr[p]);
			chk("mode out", m_ptr[p], {24'h0, mode_o[p]});
			m_ptr[p] = 32'h0;
			wr(ra(p, periph_pkg::OFF_STAT), 32'h0000000C);
			rd("status", ra(p, periph_pkg::OFF_STAT), m_stat(p));
			rd("command", ra(p, periph_pkg::OFF_CTRL), 32'h0);
			rd("int enable", ra(p, periph_pkg::OFF_IEN), 32'h0);
			wr(ra(p, periph_pkg::OFF_IEN), 32'h5);
			wr(ra(p, periph_pkg::OFF_IEN), 32'h0);
			m_mask[p] = 4'h5;
			rd("mask", ra(p, periph_pkg::OFF_IMASK), 32'h5);
			chk_irq(p);
			for (i = 2; i >= 0; i -= 2) begin
				wr(ra(p, periph_pkg::OFF_IDIS), 32'h4 >> (2 - i));
				m_mask[p] = m_mask[p] & ~(4'h4 >> (2 - i));
				rd("mask", ra(p, periph_pkg::OFF_IMASK), {28'h0, m_mask[p]});
				chk_irq(p);
			end
		end
		$display("test register_access done");
		foreach (bad_q[j]) begin
			bus_master_model_inst.xfer(1'b0, bad_q[j], 32'h0, q, e, s, k);
			chk("error flag", {31'h0, j < 4}, {31'h0, e});
			chk("irqc select", {31'h0, j == 4}, {31'h0, s});
		end
		$display("test address_map done");
		for (c = 0; c < 4; c++) begin
			p = c >> 1;
			d = c & 1;
			n = 1 + ($urandom % 4);
			m_ptr[c] = $urandom;
			m_cnt[c] = n;
			wr(ra(p, d ? periph_pkg::OFF_TX_PTR : periph_pkg::OFF_RX_PTR), m_ptr[c]);
			wr(ra(p, d ? periph_pkg::OFF_TX_CNT : periph_pkg::OFF_RX_CNT), n);
			wr(ra(p, periph_pkg::OFF_IEN), 32'h1 << d);
			m_mask[p] = 4'h1 << d;
			burst(c, 1);
			wr(ra(p, periph_pkg::OFF_CTRL), d ? 32'h4 : 32'h1);
			m_en[c] = 1;
			wr(ra(p, periph_pkg::OFF_CTRL), 32'h0);
			rd("status", ra(p, periph_pkg::OFF_STAT), m_stat(p));
			chk_irq(p);
			burst(c, n + 1);
			rd("pointer", ra(p, d ? periph_pkg::OFF_TX_PTR : periph_pkg::OFF_RX_PTR), m_ptr[c]);
			rd("count", ra(p, d ? periph_pkg::OFF_TX_CNT : periph_pkg::OFF_RX_CNT), 32'h0);
			rd("status", ra(p, periph_pkg::OFF_STAT), m_stat(p));
			chk_irq(p);
			wr(ra(p, periph_pkg::OFF_CTRL), d ? 32'hC : 32'h3);
			m_en[c] = 0;
			wr(ra(p, periph_pkg::OFF_IDIS), 32'h1 << d);
			m_mask[p] = 4'h0;
			rd("status", ra(p, periph_pkg::OFF_STAT), m_stat(p));
		end
		$display("test data_channels done");
		test_done();
	end
endmodule // test_peripheral_regs_irq_and_pdc

// ---- pkg/periph_pkg.sv ----
// shared constants for the peripheral register bank and its data channels
// assumes a 32-bit peripheral bus with zero-wait single-word accesses
package periph_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 16;
	localparam int WIN_BITS = 14;
	localparam int IRQC_WIN_BITS = 12;
	localparam int PTR_W = 32;
	localparam int CNT_W = 16;
	localparam int MODE_W = 8;
	localparam int SR_W = 4;
	localparam int NUM_PORTS = 2;
	localparam int NUM_CHAN = 4;

	// windows selected by the top address bits
	localparam logic [1:0] WIN_PORT0 = 2'h0;
	localparam logic [1:0] WIN_PORT1 = 2'h1;
	localparam logic [1:0] WIN_IRQC = 2'h2;
	localparam logic [3:0] IRQC_PAGE = 4'h8;

	// register offsets inside a serial port window
	localparam logic [WIN_BITS-1:0] OFF_CTRL = 14'h0000;
	localparam logic [WIN_BITS-1:0] OFF_MODE = 14'h0004;
	localparam logic [WIN_BITS-1:0] OFF_IEN = 14'h0008;
	localparam logic [WIN_BITS-1:0] OFF_IDIS = 14'h000C;
	localparam logic [WIN_BITS-1:0] OFF_IMASK = 14'h0010;
	localparam logic [WIN_BITS-1:0] OFF_STAT = 14'h0014;
	localparam logic [WIN_BITS-1:0] OFF_RX_PTR = 14'h0030;
	localparam logic [WIN_BITS-1:0] OFF_RX_CNT = 14'h0034;
	localparam logic [WIN_BITS-1:0] OFF_TX_PTR = 14'h0038;
	localparam logic [WIN_BITS-1:0] OFF_TX_CNT = 14'h003C;

	// command bits
	localparam int CTRL_RX_EN = 0;
	localparam int CTRL_RX_DIS = 1;
	localparam int CTRL_TX_EN = 2;
	localparam int CTRL_TX_DIS = 3;

	// status bits
	localparam int SR_END_RX = 0;
	localparam int SR_END_TX = 1;
	localparam int SR_RX_ON = 2;
	localparam int SR_TX_ON = 3;

	localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
	localparam logic [SR_W-1:0] MASK_RST = 4'h0;
	localparam logic [1:0] CHEN_RST = 2'h0;
	localparam logic [PTR_W-1:0] PTR_RST = 32'h00000000;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [PTR_W-1:0] XFER_SIZE = 32'h00000001;
endpackage

// ---- rtl/dma_channel.sv ----
// one data channel: address pointer, transfer counter, transfer handshake
// assumes req_i comes from serial port logic on the same clock
`timescale 1ns/1ps
module dma_channel (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic ptr_wr_i,
	input wire logic cnt_wr_i,
	input wire logic [periph_pkg::DATA_W-1:0] wdata_i,
	input wire logic enable_i,
	input wire logic req_i,
	output logic [periph_pkg::PTR_W-1:0] ptr_o,
	output logic [periph_pkg::CNT_W-1:0] cnt_o,
	output logic ack_o,
	output logic [periph_pkg::PTR_W-1:0] addr_o
);
	logic [periph_pkg::PTR_W-1:0] ptr_reg, ptr_next, addr_reg, addr_next;
	logic [periph_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic ack_reg, ack_next;

	always_comb begin
		ptr_next = ptr_reg;
		cnt_next = cnt_reg;
		addr_next = addr_reg;
		ack_next = 1'b0;
		if (req_i && enable_i && (cnt_reg != periph_pkg::CNT_RST)) begin // [RULE_16]
			addr_next = ptr_reg;
			ptr_next = ptr_reg + periph_pkg::XFER_SIZE;
			cnt_next = cnt_reg - 16'h0001;
			ack_next = 1'b1;
		end
		// a software reload overrides the transfer's pointer or counter update in the same cycle; the ack and address still go out
		if (ptr_wr_i) begin
			ptr_next = wdata_i[periph_pkg::PTR_W-1:0];
		end
		if (cnt_wr_i) begin
			cnt_next = wdata_i[periph_pkg::CNT_W-1:0];
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ptr_reg <= periph_pkg::PTR_RST;
			cnt_reg <= periph_pkg::CNT_RST;
			addr_reg <= periph_pkg::PTR_RST;
			ack_reg <= 1'b0;
		end else begin
			ptr_reg <= ptr_next;
			cnt_reg <= cnt_next;
			addr_reg <= addr_next;
			ack_reg <= ack_next;
		end
	end

	assign ptr_o = ptr_reg;
	assign cnt_o = cnt_reg;
	assign ack_o = ack_reg;
	assign addr_o = addr_reg;

	a_cnt_step: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_16]
		(req_i && enable_i && cnt_reg != 16'h0000 && !ptr_wr_i && !cnt_wr_i) |=>
		(cnt_reg == $past(cnt_reg) - 16'h0001) && (ptr_reg == $past(ptr_reg) + 32'h00000001) && ack_reg)
		else $error("channel did not advance on a transfer");

	a_stop_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_16]
		(cnt_reg == 16'h0000 && !cnt_wr_i && !ptr_wr_i) |=> (cnt_reg == 16'h0000) && !ack_reg && $stable(ptr_reg))
		else $error("channel moved with an empty counter");
endmodule // dma_channel

// ---- rtl/periph_regs.sv ----
// register bank of two serial ports with their four data channels
// assumes a zero-wait peripheral bus master and serial ports on mclk_i
//
// Notes on behaviour
// RULE_01: registers sit on the 32-bit bus and answer full words only.
// RULE_02: byte or half-word addresses have low bits dropped; a word access results.
// RULE_03: each port gets a 16 KB window; the interrupt controller gets 4 KB.
// RULE_04: command register is write-only; ones trigger commands, zeros do nothing.
// RULE_05: mode register reads back, holds configuration, resets to zero.
// RULE_06: status register is read-only; writes leave it unchanged.
// RULE_07: a one written to an enable register sets that shadow bit only.
// RULE_08: a one written to a disable register clears that bit; zeros ignored.
// RULE_09: unused bits are written as zero by software and always read zero.
// RULE_10: interrupt source is the OR of status bits ANDed with mask bits.
// RULE_11: mask is readable, changed only via interrupt enable and disable registers.
// RULE_12: four data channels serve the two serial ports.
// RULE_13: each port has a receive and transmit channel inside its own window.
// RULE_14: each channel has a 32-bit address pointer and 16-bit transfer counter.
// RULE_15: a finished channel sets an end flag in status; unmasked, it interrupts.
// RULE_16: each transfer advances the pointer, decrements the counter, stops at zero.
`timescale 1ns/1ps
module periph_regs (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [periph_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [periph_pkg::DATA_W-1:0] pwdata_i,
	output logic [periph_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irqc_sel_o,
	output logic [periph_pkg::NUM_PORTS-1:0] irq_o,
	output logic [periph_pkg::NUM_PORTS-1:0][periph_pkg::MODE_W-1:0] mode_o,
	input wire logic [periph_pkg::NUM_PORTS-1:0] rx_req_i,
	input wire logic [periph_pkg::NUM_PORTS-1:0] tx_req_i,
	output logic [periph_pkg::NUM_PORTS-1:0] rx_ack_o,
	output logic [periph_pkg::NUM_PORTS-1:0] tx_ack_o,
	output logic [periph_pkg::NUM_PORTS-1:0][periph_pkg::PTR_W-1:0] rx_addr_o,
	output logic [periph_pkg::NUM_PORTS-1:0][periph_pkg::PTR_W-1:0] tx_addr_o
);
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic setup_w, access_w, wr_w, port_hit_w, irqc_hit_w;
	logic [1:0] win_w;
	logic port_idx_w;
	logic [periph_pkg::WIN_BITS-1:0] off_w;

	assign setup_w = psel_i && !penable_i;
	assign access_w = psel_i && penable_i;
	assign wr_w = access_w && pwrite_i;
	assign win_w = paddr_i[periph_pkg::ADDR_W-1:periph_pkg::WIN_BITS]; // [RULE_03]
	assign port_hit_w = (win_w == periph_pkg::WIN_PORT0) || (win_w == periph_pkg::WIN_PORT1); // [RULE_03]
	assign port_idx_w = win_w[0];
	// the interrupt controller window is only the first 4 KB of its slot
	assign irqc_hit_w = (paddr_i[periph_pkg::ADDR_W-1:periph_pkg::IRQC_WIN_BITS] == periph_pkg::IRQC_PAGE); // [RULE_03]
	// lane bits are dropped so narrow accesses become word accesses
	assign off_w = {paddr_i[periph_pkg::WIN_BITS-1:2], 2'b00}; // [RULE_01] [RULE_02]

	// ----------------------------------------------------------------
	// per-port control state
	// ----------------------------------------------------------------
	logic [periph_pkg::MODE_W-1:0] mode_reg [periph_pkg::NUM_PORTS];
	logic [periph_pkg::MODE_W-1:0] mode_next [periph_pkg::NUM_PORTS];
	logic [periph_pkg::SR_W-1:0] imask_reg [periph_pkg::NUM_PORTS];
	logic [periph_pkg::SR_W-1:0] imask_next [periph_pkg::NUM_PORTS];
	logic [1:0] chen_reg [periph_pkg::NUM_PORTS];
	logic [1:0] chen_next [periph_pkg::NUM_PORTS];
	logic [periph_pkg::NUM_PORTS-1:0] irq_reg, irq_next;
	logic [periph_pkg::SR_W-1:0] status_w [periph_pkg::NUM_PORTS];

	// channel wiring: channel 2p is receive, 2p+1 transmit of port p
	logic [periph_pkg::NUM_CHAN-1:0] ptr_wr_w, cnt_wr_w, ch_en_w, ch_req_w, ch_ack_w;
	logic [periph_pkg::PTR_W-1:0] ch_ptr_w [periph_pkg::NUM_CHAN];
	logic [periph_pkg::PTR_W-1:0] ch_addr_w [periph_pkg::NUM_CHAN];
	logic [periph_pkg::CNT_W-1:0] ch_cnt_w [periph_pkg::NUM_CHAN];

	always_comb begin
		for (int p = 0; p < periph_pkg::NUM_PORTS; p++) begin
			mode_next[p] = mode_reg[p];
			imask_next[p] = imask_reg[p];
			chen_next[p] = chen_reg[p];
			// end flags are live: counter at zero means the programmed count is done
			status_w[p] = {chen_reg[p][1], chen_reg[p][0],
				ch_cnt_w[2*p+1] == periph_pkg::CNT_RST, ch_cnt_w[2*p] == periph_pkg::CNT_RST}; // [RULE_15]
			irq_next[p] = |(status_w[p] & imask_reg[p]); // [RULE_10] [RULE_15]
			if (wr_w && port_hit_w && (port_idx_w == p[0])) begin
				case (off_w)
					periph_pkg::OFF_CTRL: begin // [RULE_04]
						// disable wins when both commands come together
						chen_next[p][0] = (chen_reg[p][0] || pwdata_i[periph_pkg::CTRL_RX_EN])
							&& !pwdata_i[periph_pkg::CTRL_RX_DIS];
						chen_next[p][1] = (chen_reg[p][1] || pwdata_i[periph_pkg::CTRL_TX_EN])
							&& !pwdata_i[periph_pkg::CTRL_TX_DIS];
					end
					periph_pkg::OFF_MODE: begin
						mode_next[p] = pwdata_i[periph_pkg::MODE_W-1:0]; // [RULE_05]
					end
					periph_pkg::OFF_IEN: begin
						imask_next[p] = imask_reg[p] | pwdata_i[periph_pkg::SR_W-1:0]; // [RULE_07] [RULE_11]
					end
					periph_pkg::OFF_IDIS: begin
						imask_next[p] = imask_reg[p] & ~pwdata_i[periph_pkg::SR_W-1:0]; // [RULE_08] [RULE_11]
					end
					default: begin
						// status and mask view are not writable here
						mode_next[p] = mode_reg[p]; // [RULE_06]
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int p = 0; p < periph_pkg::NUM_PORTS; p++) begin
				mode_reg[p] <= periph_pkg::MODE_RST;
				imask_reg[p] <= periph_pkg::MASK_RST;
				chen_reg[p] <= periph_pkg::CHEN_RST;
			end
			irq_reg <= '0;
		end else begin
			for (int p = 0; p < periph_pkg::NUM_PORTS; p++) begin
				mode_reg[p] <= mode_next[p];
				imask_reg[p] <= imask_next[p];
				chen_reg[p] <= chen_next[p];
			end
			irq_reg <= irq_next;
		end
	end

	// ----------------------------------------------------------------
	// data channels
	// ----------------------------------------------------------------
	for (genvar c = 0; c < periph_pkg::NUM_CHAN; c++) begin : g_chan // [RULE_12]
		localparam logic PORT = (c / 2) == 1;
		localparam logic IS_TX = (c % 2) == 1;
		localparam logic [periph_pkg::WIN_BITS-1:0] PTR_OFF = IS_TX ? periph_pkg::OFF_TX_PTR : periph_pkg::OFF_RX_PTR;
		localparam logic [periph_pkg::WIN_BITS-1:0] CNT_OFF = IS_TX ? periph_pkg::OFF_TX_CNT : periph_pkg::OFF_RX_CNT;
		// channel registers live inside their own port window
		assign ptr_wr_w[c] = wr_w && port_hit_w && (port_idx_w == PORT) && (off_w == PTR_OFF); // [RULE_13]
		assign cnt_wr_w[c] = wr_w && port_hit_w && (port_idx_w == PORT) && (off_w == CNT_OFF); // [RULE_13]
		assign ch_en_w[c] = chen_reg[c/2][c%2];
		assign ch_req_w[c] = IS_TX ? tx_req_i[c/2] : rx_req_i[c/2];
		dma_channel u_chan ( // [RULE_14]
			.mclk_i(mclk_i),
			.nrst_i(nrst_i),
			.ptr_wr_i(ptr_wr_w[c]),
			.cnt_wr_i(cnt_wr_w[c]),
			.wdata_i(pwdata_i),
			.enable_i(ch_en_w[c]),
			.req_i(ch_req_w[c]),
			.ptr_o(ch_ptr_w[c]),
			.cnt_o(ch_cnt_w[c]),
			.ack_o(ch_ack_w[c]),
			.addr_o(ch_addr_w[c])
		);
	end

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	logic [periph_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	logic ready_reg, ready_next, err_reg, err_next, irqc_reg, irqc_next;
	logic rsel_w;

	assign rsel_w = port_idx_w;

	always_comb begin
		// unused bits stay zero because every field is zero-extended
		rdata_next = '0; // [RULE_09]
		err_next = 1'b0;
		ready_next = setup_w;
		irqc_next = setup_w && irqc_hit_w;
		if (setup_w) begin
			if (port_hit_w) begin
				case (off_w)
					periph_pkg::OFF_CTRL: rdata_next = '0; // [RULE_04]
					periph_pkg::OFF_IEN: rdata_next = '0;
					periph_pkg::OFF_IDIS: rdata_next = '0;
					periph_pkg::OFF_MODE: rdata_next = {24'h000000, mode_reg[rsel_w]}; // [RULE_05]
					periph_pkg::OFF_IMASK: rdata_next = {28'h0000000, imask_reg[rsel_w]}; // [RULE_11]
					periph_pkg::OFF_STAT: rdata_next = {28'h0000000, status_w[rsel_w]}; // [RULE_06]
					periph_pkg::OFF_RX_PTR: rdata_next = ch_ptr_w[{rsel_w, 1'b0}];
					periph_pkg::OFF_RX_CNT: rdata_next = {16'h0000, ch_cnt_w[{rsel_w, 1'b0}]};
					periph_pkg::OFF_TX_PTR: rdata_next = ch_ptr_w[{rsel_w, 1'b1}];
					periph_pkg::OFF_TX_CNT: rdata_next = {16'h0000, ch_cnt_w[{rsel_w, 1'b1}]};
					default: err_next = 1'b1;
				endcase
			end else if (!irqc_hit_w) begin
				err_next = 1'b1; // [RULE_03]
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_reg <= '0;
			ready_reg <= 1'b0;
			err_reg <= 1'b0;
			irqc_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg <= err_next;
			irqc_reg <= irqc_next;
		end
	end

	assign prdata_o = rdata_reg;
	assign pready_o = ready_reg;
	assign pslverr_o = err_reg;
	assign irqc_sel_o = irqc_reg;
	assign irq_o = irq_reg;

	for (genvar p = 0; p < periph_pkg::NUM_PORTS; p++) begin : g_port_out
		assign mode_o[p] = mode_reg[p];
		assign rx_ack_o[p] = ch_ack_w[2*p];
		assign tx_ack_o[p] = ch_ack_w[2*p+1];
		assign rx_addr_o[p] = ch_addr_w[2*p];
		assign tx_addr_o[p] = ch_addr_w[2*p+1];
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_mode_write: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_05]
		(wr_w && win_w == 2'h0 && off_w == 14'h0004) |=> mode_o[0] == $past(pwdata_i[7:0]))
		else $error("mode write not held");

	a_status_ro: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_06]
		(wr_w && win_w == 2'h0 && off_w == 14'h0014) |=> (chen_reg[0] == $past(chen_reg[0])) && $stable(imask_reg[0]))
		else $error("status write changed state");

	a_ien_sets: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_07]
		(wr_w && win_w == 2'h0 && off_w == 14'h0008) |=> imask_reg[0] == ($past(imask_reg[0]) | $past(pwdata_i[3:0])))
		else $error("enable write did not set mask bits");

	a_idis_clears: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_08]
		(wr_w && win_w == 2'h1 && off_w == 14'h000C) |=> imask_reg[1] == ($past(imask_reg[1]) & ~$past(pwdata_i[3:0])))
		else $error("disable write did not clear mask bits");

	a_cmd_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_04]
		(wr_w && win_w == 2'h0 && off_w == 14'h0000 && pwdata_i[3:0] == 4'h0) |=> $stable(chen_reg[0]))
		else $error("zero command changed channel enables");

	a_unused_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_09]
		(setup_w && port_hit_w && off_w == 14'h0004) |=> pready_o && prdata_o[31:8] == 24'h000000)
		else $error("unused bits read nonzero");

	a_irq_source: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_10]
		1'b1 |=> irq_o[1] == $past(|(status_w[1] & imask_reg[1])))
		else $error("interrupt source mismatch");

	a_window_err: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_03]
		(setup_w && win_w == 2'h2 && paddr_i[13:12] != 2'h0) |=> pslverr_o && !irqc_sel_o)
		else $error("outside interrupt controller window not refused");

	a_end_irq: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [RULE_15]
		(ch_cnt_w[0] == 16'h0000 && imask_reg[0][0]) |=> irq_o[0])
		else $error("end of receive did not interrupt");
endmodule // periph_regs
